/* core/pwt_pkg.sv */
// package: register map, field positions and encodings of the pwm timer channel
package pwt_pkg;
  // register byte addresses
  localparam logic [15:0] ADDR_CLK_SETUP = 16'h506b;
  localparam logic [15:0] ADDR_CTRL      = 16'h5460;
  localparam logic [15:0] ADDR_COUNT     = 16'h5462;
  localparam logic [15:0] ADDR_CC_CTRL   = 16'h5464;
  localparam logic [15:0] ADDR_CCA       = 16'h5466;
  localparam logic [15:0] ADDR_CCB       = 16'h5468;
  localparam logic [15:0] ADDR_IRQ_EN    = 16'h546a;
  localparam logic [15:0] ADDR_IRQ_FLG   = 16'h546c;
  localparam int          AW             = 16;
  // count clock setup fields
  localparam int CLK_GATE_BIT = 0;
  localparam int CLK_SRC_LSB  = 2;
  localparam int CLK_DIV_LSB  = 4;
  // counter control fields
  localparam int CTL_RUN_BIT   = 0;
  localparam int CTL_CLR_BIT   = 1;
  localparam int CTL_ONE_BIT   = 2;
  localparam int CTL_BUF_BIT   = 3;
  localparam int CTL_SEL_LSB   = 4;
  localparam int CTL_HALF_BIT  = 6;
  // compare/capture control fields
  localparam int CC_A_CAP_BIT  = 0;
  localparam int CC_A_POL_BIT  = 1;
  localparam int CC_A_WAV_LSB  = 4;
  localparam int CC_A_EDG_LSB  = 6;
  localparam int CC_B_CAP_BIT  = 8;
  localparam int CC_B_POL_BIT  = 9;
  localparam int CC_B_WAV_LSB  = 12;
  localparam int CC_B_EDG_LSB  = 14;
  // interrupt bit positions
  localparam int IRQ_CMP_A = 0;
  localparam int IRQ_CMP_B = 1;
  localparam int IRQ_CAP_A = 2;
  localparam int IRQ_CAP_B = 3;
  localparam int IRQ_OVR_A = 4;
  localparam int IRQ_OVR_B = 5;
  localparam int NIRQ      = 6;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  // clock sources
  localparam logic [1:0] SRC_RC   = 2'h0;
  localparam logic [1:0] SRC_LOW  = 2'h1;
  localparam logic [1:0] SRC_HIGH = 2'h2;
  localparam logic [1:0] SRC_EXT  = 2'h3;
  localparam logic [3:0] DIV_LOW_MAX = 4'h8;
  // capture edges
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // output waveforms
  localparam logic [1:0] WAV_OFF    = 2'h0;
  localparam logic [1:0] WAV_SETCLR = 2'h1;
  localparam logic [1:0] WAV_TOG_A  = 2'h2;
  localparam logic [1:0] WAV_TOG_B  = 2'h3;
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } pwt_bus_t;
endpackage

/* core/pwt_timer.sv */
// one pwm timer channel: prescaler, 16-bit counter, two compare/capture units
`timescale 1ns/100ps
module pwt_timer
  import pwt_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [AW-1:0] avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [15:0]   avs_writedata_i,
  input  wire logic [1:0]    avs_byteenable_i,
  output logic      [15:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  input  wire logic          osc_rc_i,
  input  wire logic          osc_low_i,
  input  wire logic          osc_high_i,
  input  wire logic          clk_ext_i,
  input  wire logic          capture_a_i,
  input  wire logic          capture_b_i,
  output logic               timer_output_a_o,
  output logic               timer_output_b_o,
  output logic               irq_o
);

  // ==========================================================
  // pin synchronisers (three stages, first read only by second)
  // ==========================================================
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] sync3_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      sync3_r <= 6'h00;
    end else begin
      sync1_r <= {capture_b_i, capture_a_i, clk_ext_i, osc_high_i, osc_low_i, osc_rc_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  logic [7:0]      clk_setup_r;
  logic [15:0]     ctrl_r;
  logic [15:0]     cc_ctrl_r;
  logic [15:0]     cca_r;
  logic [15:0]     ccb_r;
  logic [15:0]     cca_live_r;
  logic [15:0]     ccb_live_r;
  logic [NIRQ-1:0] irq_en_r;
  logic [NIRQ-1:0] irq_flg_r;
  logic [CW-1:0]   count_r;
  pwt_bus_t        bus_r;

  logic wr_hit;
  logic lo_be;
  logic hi_be;
  // writes land at the edge where the master sees waitrequest low
  assign wr_hit = avs_write_i && (bus_r == BUS_ACK);
  assign lo_be  = avs_byteenable_i[0];
  assign hi_be  = avs_byteenable_i[1];

  // ==========================================================
  // count clock source, prescaler, gate
  // ==========================================================
  logic [1:0]  src;
  logic [3:0]  div;
  logic [3:0]  div_eff;
  logic        src_lvl;
  logic        src_prev_r;
  logic        src_tick;
  logic [14:0] pre_r;
  logic        cnt_tick;
  logic        half_r;
  logic        step;

  assign src = clk_setup_r[CLK_SRC_LSB +: 2];
  assign div = clk_setup_r[CLK_DIV_LSB +: 4];
  always_comb begin
    unique case (src)
      SRC_RC:   src_lvl = sync2_r[0];
      SRC_LOW:  src_lvl = sync2_r[1];
      SRC_HIGH: src_lvl = sync2_r[2];
      default:  src_lvl = sync2_r[3];
    endcase
    // low crystal limited to divide-by-256
    div_eff = (src == SRC_LOW && div > DIV_LOW_MAX) ? DIV_LOW_MAX : div;
  end
  assign src_tick = src_lvl && !src_prev_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_prev_r <= 1'b0;
      pre_r      <= 15'h0000;
    end else begin
      src_prev_r <= src_lvl;
      if (!clk_setup_r[CLK_GATE_BIT])
        pre_r <= 15'h0000;
      else if (src_tick)
        pre_r <= pre_r + 15'h0001;
    end
  end

  // tick when the low div bits of the prescaler roll over
  logic [14:0] pre_mask;
  assign pre_mask = 15'((16'h0001 << div_eff) - 16'h0001);
  assign cnt_tick = clk_setup_r[CLK_GATE_BIT] && src_tick
                    && ((pre_r & pre_mask) == pre_mask);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      half_r <= 1'b0;
    else if (cnt_tick)
      half_r <= ~half_r;
  end
  assign step = cnt_tick && (!ctrl_r[CTL_HALF_BIT] || half_r);

  // ==========================================================
  // counter and compare
  // ==========================================================
  logic cmp_a;
  logic cmp_b;
  logic clr_req;
  assign clr_req = wr_hit && avs_address_i == ADDR_CTRL && lo_be
                   && avs_writedata_i[CTL_CLR_BIT];
  assign cmp_a = step && ctrl_r[CTL_RUN_BIT] && !cc_ctrl_r[CC_A_CAP_BIT]
                 && count_r == cca_live_r;
  assign cmp_b = step && ctrl_r[CTL_RUN_BIT] && !cc_ctrl_r[CC_B_CAP_BIT]
                 && count_r == ccb_live_r;

  logic run_stop;
  assign run_stop = cmp_b && ctrl_r[CTL_ONE_BIT];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      count_r <= '0;
    else if (clr_req)
      count_r <= '0;
    else if (step && ctrl_r[CTL_RUN_BIT]) begin
      if (cmp_b)
        count_r <= '0;
      else
        count_r <= count_r + 1'b1;
    end
  end

  // live compare values: buffered copy updates at period end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cca_live_r <= RST_WORD;
      ccb_live_r <= RST_WORD;
    end else if (!ctrl_r[CTL_BUF_BIT] || cmp_b || !ctrl_r[CTL_RUN_BIT]) begin
      cca_live_r <= cca_r;
      ccb_live_r <= ccb_r;
    end
  end

  // ==========================================================
  // capture edges
  // ==========================================================
  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    edge_hit = (sel[0] && now && !was) || (sel[1] && !now && was);
  endfunction
  logic cap_a;
  logic cap_b;
  assign cap_a = cc_ctrl_r[CC_A_CAP_BIT]
                 && edge_hit(cc_ctrl_r[CC_A_EDG_LSB +: 2], sync2_r[4], sync3_r[4]);
  assign cap_b = cc_ctrl_r[CC_B_CAP_BIT]
                 && edge_hit(cc_ctrl_r[CC_B_EDG_LSB +: 2], sync2_r[5], sync3_r[5]);

  // ==========================================================
  // register writes
  // ==========================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_setup_r <= 8'h00;
      ctrl_r      <= RST_WORD;
      cc_ctrl_r   <= RST_WORD;
      irq_en_r    <= '0;
    end else begin
      // one-shot drops the run bit at period end; a write in that cycle wins
      if (run_stop)
        ctrl_r[CTL_RUN_BIT] <= 1'b0;
      if (wr_hit) begin
        if (avs_address_i == ADDR_CLK_SETUP && lo_be)
          clk_setup_r <= avs_writedata_i[7:0] & 8'hfd;
        if (avs_address_i == ADDR_CTRL && lo_be)
          ctrl_r <= {9'h000, avs_writedata_i[6:2], 1'b0, avs_writedata_i[0]};
        if (avs_address_i == ADDR_CC_CTRL) begin
          if (lo_be)
            cc_ctrl_r[7:0] <= avs_writedata_i[7:0] & 8'hf3;
          if (hi_be)
            cc_ctrl_r[15:8] <= avs_writedata_i[15:8] & 8'hf3;
        end
        if (avs_address_i == ADDR_IRQ_EN && lo_be)
          irq_en_r <= avs_writedata_i[NIRQ-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cca_r <= RST_WORD;
      ccb_r <= RST_WORD;
    end else begin
      if (cap_a)
        cca_r <= count_r;
      else if (wr_hit && avs_address_i == ADDR_CCA) begin
        if (lo_be) cca_r[7:0] <= avs_writedata_i[7:0];
        if (hi_be) cca_r[15:8] <= avs_writedata_i[15:8];
      end
      if (cap_b)
        ccb_r <= count_r;
      else if (wr_hit && avs_address_i == ADDR_CCB) begin
        if (lo_be) ccb_r[7:0] <= avs_writedata_i[7:0];
        if (hi_be) ccb_r[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // ==========================================================
  // interrupt flags: set wins over write-one clear
  // ==========================================================
  logic [NIRQ-1:0] ev;
  logic [NIRQ-1:0] clr;
  assign ev = {cap_b && irq_flg_r[IRQ_CAP_B], cap_a && irq_flg_r[IRQ_CAP_A],
               cap_b, cap_a, cmp_b, cmp_a};
  assign clr = (wr_hit && avs_address_i == ADDR_IRQ_FLG && lo_be)
               ? avs_writedata_i[NIRQ-1:0] : '0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flg_r <= '0;
      irq_o     <= 1'b0;
    end else begin
      irq_flg_r <= (irq_flg_r & ~clr) | ev;
      irq_o     <= |(((irq_flg_r & ~clr) | ev) & irq_en_r);
    end
  end

  // ==========================================================
  // timer outputs
  // ==========================================================
  function automatic logic wave_nxt(input logic [1:0] m, input logic cur,
                                    input logic ma, input logic mb);
    unique case (m)
      WAV_OFF:    wave_nxt = 1'b0;
      WAV_SETCLR: wave_nxt = mb ? 1'b0 : (ma ? 1'b1 : cur);
      WAV_TOG_A:  wave_nxt = ma ? ~cur : cur;
      default:    wave_nxt = mb ? ~cur : cur;
    endcase
  endfunction
  logic wav_a_r;
  logic wav_b_r;
  logic wav_a_nxt;
  logic wav_b_nxt;
  assign wav_a_nxt = wave_nxt(cc_ctrl_r[CC_A_WAV_LSB +: 2], wav_a_r, cmp_a, cmp_b);
  assign wav_b_nxt = wave_nxt(cc_ctrl_r[CC_B_WAV_LSB +: 2], wav_b_r, cmp_a, cmp_b);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wav_a_r          <= 1'b0;
      wav_b_r          <= 1'b0;
      timer_output_a_o <= 1'b0;
      timer_output_b_o <= 1'b0;
    end else begin
      wav_a_r          <= wav_a_nxt;
      wav_b_r          <= wav_b_nxt;
      timer_output_a_o <= wav_a_nxt ^ cc_ctrl_r[CC_A_POL_BIT];
      timer_output_b_o <= wav_b_nxt ^ cc_ctrl_r[CC_B_POL_BIT];
    end
  end

  // ==========================================================
  // avalon slave: one wait cycle for every access
  // ==========================================================
  logic [15:0] rd_mux;
  always_comb begin
    unique case (avs_address_i)
      ADDR_CLK_SETUP: rd_mux = {8'h00, clk_setup_r};
      ADDR_CTRL:      rd_mux = ctrl_r;
      ADDR_COUNT:     rd_mux = count_r;
      ADDR_CC_CTRL:   rd_mux = cc_ctrl_r;
      ADDR_CCA:       rd_mux = cca_r;
      ADDR_CCB:       rd_mux = ccb_r;
      ADDR_IRQ_EN:    rd_mux = {10'h000, irq_en_r};
      ADDR_IRQ_FLG:   rd_mux = {10'h000, irq_flg_r};
      default:        rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_r             <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 16'h0000;
    end else begin
      unique case (bus_r)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_r             <= BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= rd_mux;
          end
        end
        BUS_ACK: begin
          bus_r             <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  a_clear_zeroes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clr_req |=> count_r == '0) else $error("counter not cleared");
  a_stop_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ctrl_r[CTL_RUN_BIT] && !clr_req) |=> $stable(count_r))
    else $error("counter moved while stopped");
  a_gate_blocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !clk_setup_r[CLK_GATE_BIT] |-> !step) else $error("count while gated");
  a_oneshot_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    run_stop |=> count_r == '0) else $error("one-shot did not restart at zero");
  a_capture_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cap_a |=> cca_r == $past(count_r)) else $error("capture a lost");
  a_flag_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmp_a |=> irq_flg_r[IRQ_CMP_A]) else $error("compare a flag missed");
  a_overrun_b: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cap_b && irq_flg_r[IRQ_CAP_B]) |=> irq_flg_r[IRQ_OVR_B])
    else $error("overrun b missed");
  a_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 (irq_o == |($past(irq_flg_r & ~clr | ev) & $past(irq_en_r))))
    else $error("irq mismatch");
  a_invert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 timer_output_a_o == (wav_a_r ^ $past(cc_ctrl_r[CC_A_POL_BIT])))
    else $error("output a polarity wrong");
  a_oneshot_halt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (run_stop && !wr_hit) |=> !ctrl_r[CTL_RUN_BIT])
    else $error("one-shot kept running");
  a_overrun_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cap_a && irq_flg_r[IRQ_CAP_A]) |=> irq_flg_r[IRQ_OVR_A])
    else $error("overrun a missed");
  a_flag_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (clr[IRQ_CMP_A] && !ev[IRQ_CMP_A]) |=> !irq_flg_r[IRQ_CMP_A])
    else $error("compare a flag not cleared");
  a_half_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_r[CTL_HALF_BIT] && !half_r) |-> !step)
    else $error("half clock mode stepped early");
  a_b_wraps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmp_b && !clr_req) |=> count_r == '0)
    else $error("compare b did not restart counter");

endmodule

/* testbench/pwt_pin_model.sv */
// far side model: oscillator sources, capture pins, timer output watcher
`timescale 1ns/100ps
module pwt_pin_model
  import pwt_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic cap_a_lvl_i,
  input  wire logic cap_b_lvl_i,
  input  wire logic timer_output_a_i,
  output logic      osc_rc_o,
  output logic      osc_low_o,
  output logic      osc_high_o,
  output logic      clk_ext_o,
  output logic      capture_a_o,
  output logic      capture_b_o,
  output int        rise_a_o
);
  // ==========================================
  // source clocks, all well below clk_i/2
  logic [3:0] div_r;
  logic       out_a_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r    <= 4'h0;
      out_a_r  <= 1'b0;
      rise_a_o <= 0;
    end else begin
      div_r   <= div_r + 4'h1;
      out_a_r <= timer_output_a_i;
      if (timer_output_a_i && !out_a_r) begin
        rise_a_o <= rise_a_o + 1;
      end
    end
  end
  assign osc_rc_o    = div_r[1];
  assign osc_high_o  = div_r[2];
  assign osc_low_o   = div_r[3];
  assign clk_ext_o   = div_r[3];
  // capture pins follow the bench's command
  assign capture_a_o = cap_a_lvl_i;
  assign capture_b_o = cap_b_lvl_i;
endmodule

/* testbench/test_pwt_timer.sv */
// testbench: registers, counting, flags, capture and waveforms of the pwm timer
`timescale 1ns/100ps
module test_pwt_timer;
  import pwt_pkg::*;
  // ==========================================
  // signals
  logic        clk_i, rst_n_i, rd, wr, ca, cb, waitr, oa, ob, irq, rc, lo, hi, ext, pa, pb;
  logic [15:0] addr, wd, rdata, v;
  logic [31:0] q[$];
  int          rise_a, r0, errors, cmp_count, cyc;
  int          seed = 32'h9d5dd770;
  logic [15:0] adr[9] = '{ADDR_CLK_SETUP, ADDR_CTRL, ADDR_COUNT, ADDR_CC_CTRL, ADDR_CCA,
                          ADDR_CCB, ADDR_IRQ_EN, ADDR_IRQ_FLG, 16'h5470};
  pwt_timer uut(.clk_i, .rst_n_i, .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(2'b11), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitr), .osc_rc_i(rc), .osc_low_i(lo), .osc_high_i(hi),
    .clk_ext_i(ext), .capture_a_i(pa), .capture_b_i(pb), .timer_output_a_o(oa),
    .timer_output_b_o(ob), .irq_o(irq));
  pwt_pin_model pins(.clk_i, .rst_n_i, .cap_a_lvl_i(ca), .cap_b_lvl_i(cb),
    .timer_output_a_i(oa), .osc_rc_o(rc), .osc_low_o(lo), .osc_high_o(hi),
    .clk_ext_o(ext), .capture_a_o(pa), .capture_b_o(pb), .rise_a_o(rise_a));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ==========================================
  // compare, bus and closing tasks
  task chk(input string n, input logic [15:0] e, input logic [15:0] g, input logic [15:0] m);
    cmp_count++;
    if ((g & m) !== (e & m)) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e & m, g & m);
    end
  endtask
  task chkb(input string n, input logic e, input logic g);
    chk(n, {15'h0, e}, {15'h0, g}, 16'h0001);
  endtask
  // read: d is the expected value, m the mask of bits that are checked
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] m);
    @(posedge clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    if (!w) q.push_back({m, d});
    do @(posedge clk_i); while (waitr !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task test_done;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // read monitor and timeout
  always @(posedge clk_i) begin
    logic [31:0] n;
    cyc++;
    if (rd === 1'b1 && waitr === 1'b0) begin
      n = q.pop_front();
      chk("readdata", n[15:0], rdata, n[31:16]);
    end
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  // ==========================================
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 16'h0;
    wd = 16'h0;
    ca = 1'b0;
    cb = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (adr[i]) acc(0, adr[i], 16'h0000, 16'hffff);
    chkb("irq_o", 1'b0, irq);
    v = 16'($random(seed));
    acc(1, ADDR_CCA, v, 16'h0);
    acc(0, ADDR_CCA, v, 16'hffff);
    v = 16'($random(seed));
    acc(1, ADDR_CCB, v, 16'h0);
    acc(0, ADDR_CCB, v, 16'hffff);
    acc(1, ADDR_COUNT, 16'hffff, 16'h0);
    acc(0, ADDR_COUNT, 16'h0000, 16'hffff);
    acc(1, ADDR_CTRL, 16'hfffe, 16'h0);
    acc(0, ADDR_CTRL, 16'h007c, 16'hffff);
    acc(1, ADDR_CC_CTRL, 16'hffff, 16'h0);
    acc(0, ADDR_CC_CTRL, 16'hf3f3, 16'hffff);
    acc(1, ADDR_IRQ_EN, 16'hffff, 16'h0);
    acc(0, ADDR_IRQ_EN, 16'h003f, 16'hffff);
    acc(1, ADDR_CLK_SETUP, 16'h00fe, 16'h0);
    acc(0, ADDR_CLK_SETUP, 16'h00fc, 16'h00ff);
    // repeat counting with compare a and b
    acc(1, ADDR_CTRL, 16'h0000, 16'h0);
    acc(1, ADDR_CC_CTRL, 16'h0000, 16'h0);
    acc(1, ADDR_CCA, 16'h0005, 16'h0);
    acc(1, ADDR_CCB, 16'h0014, 16'h0);
    acc(1, ADDR_CLK_SETUP, 16'h0001, 16'h0);
    acc(1, ADDR_CTRL, 16'h0001, 16'h0);
    repeat (200) @(posedge clk_i);
    chkb("irq_o", 1'b1, irq);
    acc(0, ADDR_IRQ_FLG, 16'h0003, 16'h003f);
    acc(0, ADDR_COUNT, 16'h0000, 16'hffe0);
    acc(1, ADDR_CTRL, 16'h0002, 16'h0);
    acc(0, ADDR_COUNT, 16'h0000, 16'hffff);
    acc(1, ADDR_IRQ_FLG, 16'h0001, 16'h0);
    acc(0, ADDR_IRQ_FLG, 16'h0002, 16'h003f);
    acc(1, ADDR_IRQ_FLG, 16'h0002, 16'h0);
    acc(0, ADDR_IRQ_FLG, 16'h0000, 16'h003f);
    repeat (2) @(posedge clk_i);
    chkb("irq_o", 1'b0, irq);
    repeat (60) @(posedge clk_i);
    acc(0, ADDR_COUNT, 16'h0000, 16'hffff);
    acc(1, ADDR_CLK_SETUP, 16'h0000, 16'h0);
    acc(1, ADDR_CTRL, 16'h0001, 16'h0);
    repeat (60) @(posedge clk_i);
    acc(0, ADDR_COUNT, 16'h0000, 16'hffff);
    // capture a on rising edge, b on falling edge
    acc(1, ADDR_CC_CTRL, 16'h8141, 16'h0);
    acc(1, ADDR_CLK_SETUP, 16'h0001, 16'h0);
    ca <= 1'b1;
    cb <= 1'b1;
    repeat (10) @(posedge clk_i);
    acc(0, ADDR_IRQ_FLG, 16'h0004, 16'h003c);
    ca <= 1'b0;
    cb <= 1'b0;
    repeat (10) @(posedge clk_i);
    ca <= 1'b1;
    cb <= 1'b1;
    repeat (10) @(posedge clk_i);
    acc(0, ADDR_IRQ_FLG, 16'h001c, 16'h003c);
    cb <= 1'b0;
    repeat (10) @(posedge clk_i);
    acc(0, ADDR_IRQ_FLG, 16'h003c, 16'h003c);
    // output a toggles on compare a, output b off but inverted
    acc(1, ADDR_CTRL, 16'h0000, 16'h0);
    acc(1, ADDR_CC_CTRL, 16'h0220, 16'h0);
    acc(1, ADDR_CCA, 16'h0003, 16'h0);
    acc(1, ADDR_CCB, 16'h000a, 16'h0);
    r0 = rise_a;
    acc(1, ADDR_CTRL, 16'h0003, 16'h0);
    repeat (400) @(posedge clk_i);
    chkb("timer_output_b_o", 1'b1, ob);
    chkb("timer_output_a_o rises", 1'b1, (rise_a - r0) >= 3);
    // one-shot: stops at zero after compare b, run bit reads back cleared
    acc(1, ADDR_CTRL, 16'h0007, 16'h0);
    repeat (100) @(posedge clk_i);
    acc(0, ADDR_CTRL, 16'h0004, 16'hffff);
    acc(0, ADDR_COUNT, 16'h0000, 16'hffff);
    // high source, divide by 2, half clock: about one step per 32 cycles
    acc(1, ADDR_CCB, 16'hffff, 16'h0);
    acc(1, ADDR_CLK_SETUP, 16'h0019, 16'h0);
    acc(1, ADDR_CTRL, 16'h0043, 16'h0);
    repeat (320) @(posedge clk_i);
    acc(0, ADDR_COUNT, 16'h0008, 16'hfff8);
    test_done;
  end
endmodule
